//--- hdl/tcs_pkg.sv
// Purpose: shared constants for the temperature conversion sequencer
// Assumes: 25 MHz system clock, 16-bit configuration register
// Notes:   timing counts derive from times given in microseconds
package tcs_pkg;
    // ----------------------------------------------------------------
    // register map and fields
    // ----------------------------------------------------------------
    localparam logic [7:0]  CFG_PTR    = 8'h30;
    localparam logic [15:0] CFG_RESET  = 16'h0f9c;
    localparam int          EN_HI      = 15;
    localparam int          EN_LO      = 7;
    localparam int          OS_BIT     = 6;
    localparam int          SD_BIT     = 5;
    localparam int          IV_HI      = 4;
    localparam int          IV_LO      = 2;
    localparam int          BUSY_BIT   = 1;
    localparam logic [2:0]  IV_CONT    = 3'h7;
    localparam logic [2:0]  IV_FASTEST = 3'h6;

    // ----------------------------------------------------------------
    // channels
    // ----------------------------------------------------------------
    localparam int          NCH      = 9;
    localparam logic [3:0]  CH_LOCAL = 4'h0;
    localparam logic [3:0]  CH_NONE  = 4'h9;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ     = 25;
    localparam int T_LOCAL_US  = 15500;
    localparam int T_REMOTE_US = 15800;
    localparam int T_UNIT_US   = 250000;
    localparam int LOCAL_CYC   = T_LOCAL_US * CLK_MHZ;
    localparam int REMOTE_CYC  = T_REMOTE_US * CLK_MHZ;
    localparam int UNIT_CYC    = T_UNIT_US * CLK_MHZ;
    localparam int CONV_W      = 20;

    typedef enum logic [3:0] {
        ST_OFF   = 4'h1,
        ST_START = 4'h2,
        ST_BUSY  = 4'h4,
        ST_IDLE  = 4'h8
    } tcs_state_t;
endpackage

//--- hdl/tcs_conv_if.sv
// Purpose: start/done handshake between sequencer and converter model
// Assumes: single clock domain
// Notes:   start and abort are one-cycle pulses, done is one cycle
`timescale 1ns/1ns
interface tcs_conv_if;
    logic       start;
    logic       abort;
    logic [3:0] chan;
    logic       done;
    logic       busy;

    modport seq  (output start, output abort, output chan, input done, input busy);
    modport conv (input start, input abort, input chan, output done, output busy);
endinterface

//--- hdl/tcs_converter.sv
// Purpose: timed model of the analog converter front end
// Assumes: one conversion per start pulse, channel 0 is local
// Notes:   abort drops an ongoing conversion with no done pulse
`timescale 1ns/1ns
module tcs_converter #(
    parameter int LOCAL_CYC  = tcs_pkg::LOCAL_CYC,
    parameter int REMOTE_CYC = tcs_pkg::REMOTE_CYC
) (
    input  wire logic clk_sys,   // system clock
    input  wire logic rstn,      // async reset, active low
    tcs_conv_if.conv  cif        // handshake with sequencer
);
    logic [tcs_pkg::CONV_W-1:0] cnt_r;
    logic                       busy_r;
    logic [tcs_pkg::CONV_W-1:0] elapsed_r;
    logic [tcs_pkg::CONV_W-1:0] len_r;

    // ----------------------------------------------------------------
    // conversion timer
    // ----------------------------------------------------------------
    // the conversion length never depends on the idle interval
    always_ff @(posedge clk_sys or negedge rstn) begin // see RULE14
        if (!rstn) begin
            busy_r <= 1'b0;
            cnt_r  <= '0;
        end else if (cif.abort) begin
            busy_r <= 1'b0;
        end else if (cif.start) begin
            busy_r <= 1'b1;
            cnt_r  <= (cif.chan == tcs_pkg::CH_LOCAL) ?           // see RULE17
                      tcs_pkg::CONV_W'(LOCAL_CYC - 1) : tcs_pkg::CONV_W'(REMOTE_CYC - 1);
        end else if (busy_r && cnt_r == '0) begin
            busy_r <= 1'b0;
        end else if (busy_r) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign cif.busy = busy_r;
    assign cif.done = busy_r && cnt_r == '0 && !cif.abort;           // see RULE19

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            elapsed_r <= '0;
            len_r     <= '0;
        end else if (cif.start) begin
            elapsed_r <= tcs_pkg::CONV_W'(1);
            len_r     <= (cif.chan == tcs_pkg::CH_LOCAL) ?
                         tcs_pkg::CONV_W'(LOCAL_CYC) : tcs_pkg::CONV_W'(REMOTE_CYC);
        end else if (busy_r) begin
            elapsed_r <= elapsed_r + 1'b1;
        end
    end

    a_conv_time_exact: assert property (@(posedge clk_sys) disable iff (!rstn) // see RULE17
        cif.done |-> elapsed_r == len_r)
        else $error("conversion length differs from channel time");

    c_conv_done: cover property (@(posedge clk_sys) disable iff (!rstn) cif.done);
endmodule

//--- hdl/tcs_conv_sequencer.sv
// Purpose: conversion sequencer behind the configuration register
// Assumes: register port strobes are synchronous to clk_sys
// Notes:   reads return data one cycle after the read strobe
// Function
// RULE1: configuration register at pointer 30h, read/write
// RULE2: bits 15:8 remote enables, bit 7 local
// RULE3: disabled channels are skipped entirely
// RULE4: local first, remotes ascending, then wrap
// RULE5: reset value 0f9ch, local and remotes 1-4 enabled
// RULE6: all-zero enables means power-down, trigger clear
// RULE7: power-down clear gives continuous conversion cycles
// RULE8: power-down aborts conversion at once
// RULE9: leaving power-down restarts at local channel
// RULE10: bit 1 shows converter busy, read-only
// RULE11: trigger in power-down starts one pass
// RULE12: after the pass return to power-down
// RULE13: readback follows the conversion-mode table
// RULE14: interval field sets idle time only
// RULE15: codes 000-110 give 16 s to 0.25 s
// RULE16: code 111 means back-to-back cycles
// RULE17: local 15.5 ms, remote 15.8 ms each
// RULE18: host writes zero to reserved bits
// RULE19: converter is start/done handshake, idle after cycle
`timescale 1ns/1ns
module tcs_conv_sequencer #(
    parameter int LOCAL_CYC  = tcs_pkg::LOCAL_CYC,   // local conversion cycles
    parameter int REMOTE_CYC = tcs_pkg::REMOTE_CYC,  // remote conversion cycles
    parameter int UNIT_CYC   = tcs_pkg::UNIT_CYC     // 0.25 s interval unit
) (
    input  wire logic        clk_sys,    // system clock, 25 MHz
    input  wire logic        rstn,       // async reset, active low
    input  wire logic [7:0]  reg_ptr,    // register pointer
    input  wire logic        reg_wr,     // write strobe
    input  wire logic [15:0] reg_wdata,  // write data
    input  wire logic        reg_rd,     // read strobe
    output logic      [15:0] reg_rdata,  // read data, registered
    output logic             conv_busy,  // converter active
    output logic      [3:0]  conv_chan,  // channel being converted
    output logic             cycle_done  // pulse at end of a cycle
);
    tcs_conv_if cif ();

    tcs_converter #(
        .LOCAL_CYC  (LOCAL_CYC),
        .REMOTE_CYC (REMOTE_CYC)
    ) u_conv (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .cif     (cif)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] next_en(input logic [8:0] en, input logic [3:0] from);
        logic [3:0] r;
        r = tcs_pkg::CH_NONE;
        for (int i = tcs_pkg::NCH - 1; i >= 0; i--) begin
            if (en[i] && 4'(i) >= from) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] idle_cycles(input logic [2:0] code);
        return 32'(UNIT_CYC) << (tcs_pkg::IV_FASTEST - code);
    endfunction

    // ----------------------------------------------------------------
    // configuration register
    // ----------------------------------------------------------------
    logic [8:0]          en_r;
    logic                os_r;
    logic                sd_r;
    logic [2:0]          iv_r;
    logic                cfg_wr;
    logic [8:0]          w_en;
    logic                w_none;
    logic                w_sd;
    logic                w_os;
    logic [15:0]         cfg_view;
    tcs_pkg::tcs_state_t st_r;
    logic [3:0]          ch_r;
    logic [31:0]         idle_cnt_r;
    logic [3:0]          first_en;
    logic [3:0]          after_en;
    logic                run_cont;
    logic                abort_now;
    logic                cycle_end;

    assign cfg_wr = reg_wr && reg_ptr == tcs_pkg::CFG_PTR;                // see RULE1
    assign w_en   = reg_wdata[tcs_pkg::EN_HI:tcs_pkg::EN_LO];            // see RULE2
    assign w_none = w_en == '0;
    assign w_sd   = reg_wdata[tcs_pkg::SD_BIT];
    assign w_os   = reg_wdata[tcs_pkg::OS_BIT];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            en_r <= tcs_pkg::CFG_RESET[tcs_pkg::EN_HI:tcs_pkg::EN_LO];    // see RULE5
            os_r <= tcs_pkg::CFG_RESET[tcs_pkg::OS_BIT];
            sd_r <= tcs_pkg::CFG_RESET[tcs_pkg::SD_BIT];
            iv_r <= tcs_pkg::CFG_RESET[tcs_pkg::IV_HI:tcs_pkg::IV_LO];
        end else if (cfg_wr) begin
            // a write wins over the end-of-pass clear of the trigger
            en_r <= w_en;
            sd_r <= w_none | w_sd;                                         // see RULE6
            os_r <= !w_none && w_sd && w_os;                               // see RULE13
            iv_r <= reg_wdata[tcs_pkg::IV_HI:tcs_pkg::IV_LO];
        end else if (cycle_end && sd_r) begin
            os_r <= 1'b0;                                                  // see RULE12
        end
    end

    // reserved bit 0 reads zero; busy ignores writes
    assign cfg_view = {en_r, os_r, sd_r, iv_r, cif.busy, 1'b0};            // see RULE10

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= (reg_ptr == tcs_pkg::CFG_PTR) ? cfg_view : 16'h0000; // see RULE1
        end
    end

    // ----------------------------------------------------------------
    // channel sequencer
    // ----------------------------------------------------------------
    assign run_cont  = !sd_r && en_r != '0;                                // see RULE7
    // any write that sets power-down, or leaves it, restarts from scratch
    assign abort_now = cfg_wr && (w_none || w_sd || sd_r);                 // see RULE8
    assign first_en  = next_en(en_r, tcs_pkg::CH_LOCAL);                   // see RULE4
    assign after_en  = next_en(en_r, ch_r + 4'h1);                         // see RULE3
    assign cycle_end = st_r == tcs_pkg::ST_BUSY && cif.done && after_en == tcs_pkg::CH_NONE;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_r       <= tcs_pkg::ST_OFF;
            ch_r       <= tcs_pkg::CH_LOCAL;
            idle_cnt_r <= '0;
        end else if (abort_now) begin
            st_r <= tcs_pkg::ST_OFF;                                       // see RULE8
        end else begin
            case (st_r)
                tcs_pkg::ST_OFF: begin
                    if ((run_cont || os_r) && first_en != tcs_pkg::CH_NONE) begin // see RULE11
                        st_r <= tcs_pkg::ST_START;
                        ch_r <= first_en;                                  // see RULE9
                    end
                end
                tcs_pkg::ST_START: begin
                    st_r <= tcs_pkg::ST_BUSY;
                end
                tcs_pkg::ST_BUSY: begin
                    if (cif.done) begin
                        if (after_en != tcs_pkg::CH_NONE) begin
                            st_r <= tcs_pkg::ST_START;
                            ch_r <= after_en;                              // see RULE4
                        end else if (sd_r) begin
                            st_r <= tcs_pkg::ST_OFF;                       // see RULE12
                        end else if (iv_r == tcs_pkg::IV_CONT) begin
                            st_r <= tcs_pkg::ST_START;                     // see RULE16
                            ch_r <= first_en;
                        end else begin
                            st_r       <= tcs_pkg::ST_IDLE;                // see RULE19
                            idle_cnt_r <= idle_cycles(iv_r) - 32'h1;       // see RULE15
                        end
                    end
                end
                tcs_pkg::ST_IDLE: begin
                    if (idle_cnt_r == '0) begin
                        st_r <= (first_en != tcs_pkg::CH_NONE) ? tcs_pkg::ST_START
                                                               : tcs_pkg::ST_OFF;
                        ch_r <= first_en;
                    end else begin
                        idle_cnt_r <= idle_cnt_r - 32'h1;                  // see RULE14
                    end
                end
                default: begin
                    st_r <= tcs_pkg::ST_OFF;
                end
            endcase
        end
    end

    assign cif.start  = st_r == tcs_pkg::ST_START && !abort_now;           // see RULE19
    assign cif.abort  = abort_now;
    assign cif.chan   = ch_r;
    assign conv_busy  = cif.busy;
    assign conv_chan  = ch_r;
    assign cycle_done = cycle_end;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    logic [31:0] idle_seen_r;
    logic [2:0]  idle_iv_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            idle_seen_r <= '0;
            idle_iv_r   <= '0;
        end else if (st_r == tcs_pkg::ST_BUSY && cycle_end) begin
            idle_seen_r <= '0;
            idle_iv_r   <= iv_r;
        end else if (st_r == tcs_pkg::ST_IDLE) begin
            idle_seen_r <= idle_seen_r + 32'h1;
        end
    end

    a_cfg_read_map: assert property ( // see RULE1
        reg_rd && reg_ptr == tcs_pkg::CFG_PTR |=> reg_rdata == $past(cfg_view))
        else $error("configuration readback mismatch");

    a_zero_en_pd: assert property ( // see RULE6
        cfg_wr && w_none |=> en_r == '0 && sd_r && !os_r && st_r == tcs_pkg::ST_OFF)
        else $error("all-zero enables did not power down");

    a_trig_readback: assert property ( // see RULE13
        cfg_wr && !w_none |=> os_r == $past(w_sd && w_os) && en_r == $past(w_en))
        else $error("trigger or enable readback wrong");

    a_skip_disabled: assert property ( // see RULE3
        cif.start |-> en_r[ch_r])
        else $error("conversion started on disabled channel");

    // a power-down write in the next cycle may cancel the start, so it is excused
    a_round_robin: assert property ( // see RULE4
        st_r == tcs_pkg::ST_BUSY && cif.done && !cycle_end && !abort_now
        |=> abort_now || (cif.start && ch_r > $past(ch_r)))
        else $error("channel order not ascending");

    a_abort_now: assert property ( // see RULE8
        cfg_wr && (w_none || w_sd) |=> st_r == tcs_pkg::ST_OFF && !cif.busy)
        else $error("power-down did not abort conversion");

    a_resume_local: assert property ( // see RULE9
        st_r == tcs_pkg::ST_OFF && run_cont && en_r[0] && !abort_now
        |=> st_r == tcs_pkg::ST_START && ch_r == tcs_pkg::CH_LOCAL)
        else $error("restart did not begin at local channel");

    a_busy_bit: assert property ( // see RULE10
        reg_rd && reg_ptr == tcs_pkg::CFG_PTR |=> reg_rdata[tcs_pkg::BUSY_BIT] == $past(cif.busy))
        else $error("busy bit does not follow converter");

    a_os_start: assert property ( // see RULE11
        (cfg_wr && w_sd && w_os && !w_none) ##1 !cfg_wr |=> cif.start)
        else $error("trigger did not start a pass");

    a_os_return: assert property ( // see RULE12
        cycle_end && sd_r && !cfg_wr |=> st_r == tcs_pkg::ST_OFF && !os_r ##1 !cif.busy)
        else $error("pass end did not return to power-down");

    a_back_to_back: assert property ( // see RULE16
        cycle_end && !sd_r && iv_r == tcs_pkg::IV_CONT && !cfg_wr |=> cif.start)
        else $error("continuous mode inserted idle time");

    a_idle_length: assert property ( // see RULE15
        st_r == tcs_pkg::ST_IDLE && idle_cnt_r == '0
        |-> idle_seen_r + 32'h1 == (32'(UNIT_CYC) << (tcs_pkg::IV_FASTEST - idle_iv_r)))
        else $error("idle interval length wrong");

    c_one_shot: cover property (cycle_end && sd_r);
    c_idle_cycle: cover property (st_r == tcs_pkg::ST_IDLE ##1 cif.start);
    c_abort: cover property (abort_now && cif.busy);
    c_wrap: cover property (cycle_end && !sd_r ##1 cif.start && ch_r == tcs_pkg::CH_LOCAL);
endmodule

//--- verif/tcs_host.sv
// Purpose: host register master that drives the configuration port
// Assumes: one strobe pulse per access, read data one edge after the strobe
// Notes:   pointer and data are inverted between accesses so stale values never help
`timescale 1ns/1ns
module tcs_host (
    input  wire logic        clk_sys,    // system clock
    output logic      [7:0]  reg_ptr,    // register pointer
    output logic             reg_wr,     // write strobe
    output logic      [15:0] reg_wdata,  // write data
    output logic             reg_rd,     // read strobe
    input  wire logic [15:0] reg_rdata   // read data
);
    initial begin
        reg_ptr   = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd    = 1'b0;
    end

    task automatic access(input logic wr, input logic [7:0] ptr, input logic [15:0] data);
        @(posedge clk_sys);
        #1;
        reg_ptr   = ptr;
        reg_wdata = data & 16'hfffe;  // reserved bit always written as zero
        reg_wr    = wr;
        reg_rd    = ~wr;
        @(posedge clk_sys);
        #1;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_ptr   = ~reg_ptr;
        reg_wdata = ~reg_wdata;
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [15:0] data);
        access(1'b1, ptr, data);
    endtask

    task automatic rd(input logic [7:0] ptr, output logic [15:0] data);
        access(1'b0, ptr, 16'h0000);
        data = reg_rdata;
    endtask
endmodule

//--- verif/temp_conversion_sequencer_test.sv
// Purpose: self-checking bench for the conversion sequencer
// Assumes: shortened conversion and interval counts
// Notes:   while mon_on is set, a monitor compares each conversion against a queue-free channel model
`timescale 1ns/1ns
module temp_conversion_sequencer_test;
    localparam int LOC  = 20;
    localparam int REM  = 24;
    localparam int UNIT = 10;
    logic        clk_sys = 1'b0;
    logic        rstn    = 1'b0;
    logic [7:0]  reg_ptr;
    logic        reg_wr;
    logic [15:0] reg_wdata;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        conv_busy;
    logic [3:0]  conv_chan;
    logic        cycle_done;
    int          miscompares = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          run_n = 0;
    int          low_n = 0;
    int          gap_exp = 0;
    int          gap_end = 1;
    logic [3:0]  cur_ch = 4'h0;
    logic [3:0]  exp_next = 4'h0;
    logic [8:0]  exp_en = 9'h1ff;
    logic        busy_q = 1'b0;
    logic        done_q = 1'b0;
    logic        mon_on = 1'b0;
    logic [15:0] rd_v;
    logic [8:0]  en_v;
    int          seed;

    always #20 clk_sys = ~clk_sys;

    tcs_conv_sequencer #(.LOCAL_CYC(LOC), .REMOTE_CYC(REM), .UNIT_CYC(UNIT)) tcs_conv_sequencer_i (
        .clk_sys(clk_sys), .rstn(rstn), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .conv_busy(conv_busy), .conv_chan(conv_chan), .cycle_done(cycle_done));

    tcs_host tcs_host_i (
        .clk_sys(clk_sys), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // ----------------------------------------------------------------
    // helpers and channel model
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [3:0] next_en(input logic [3:0] c);
        int j;
        for (int i = 1; i <= 9; i++) begin
            j = (c + i) % 9;
            if (exp_en[j]) return 4'(j);
        end
        return c;
    endfunction

    function automatic logic [3:0] last_en();
        logic [3:0] l;
        l = 4'h0;
        for (int i = 0; i < 9; i++) if (exp_en[i]) l = 4'(i);
        return l;
    endfunction

    function automatic logic [15:0] exp_cfg(input logic [15:0] w);
        if (w[15:7] == 9'h000) return 16'h0020;
        return {w[15:7], w[6] & w[5], w[5], w[4:2], 2'b00};
    endfunction

    // settled values are sampled on the falling edge to stay clear of update races
    always @(negedge clk_sys) begin
        if (conv_busy === 1'b1 && busy_q !== 1'b1) begin
            if (mon_on) begin
                chk(conv_chan, exp_next);
                if (gap_exp > 0) chk(low_n, gap_exp);
                exp_next = next_en(conv_chan);
            end
            cur_ch = conv_chan;
            run_n  = 1;
        end else if (conv_busy === 1'b1) begin
            run_n++;
        end else if (busy_q === 1'b1) begin
            if (mon_on) begin
                chk(run_n, (cur_ch == 4'h0) ? LOC : REM);
                chk(done_q, cur_ch == last_en());
                gap_exp = done_q ? gap_end : 1;
            end
            low_n = 1;
        end else begin
            low_n++;
        end
        busy_q = conv_busy;
        done_q = cycle_done;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            end_sim();
        end
    end

    // power down, then restart with a new setting so the model knows the first channel
    task automatic run_cfg(input logic [15:0] w);
        mon_on = 1'b0;
        tcs_host_i.wr(8'h30, 16'h0020);
        repeat (2) @(posedge clk_sys);
        #1;
        chk(conv_busy, 1'b0);
        exp_en   = w[15:7];
        gap_end  = (w[4:2] == 3'h7) ? 1 : (UNIT << (6 - w[4:2])) + 1;
        exp_next = next_en(4'h8);
        gap_exp  = 0;
        mon_on   = 1'b1;
        tcs_host_i.wr(8'h30, w);
        tcs_host_i.rd(8'h30, rd_v);
        chk(rd_v & 16'hfffd, exp_cfg(w));
    endtask

    task automatic wait_done(input int n);
        repeat (n) @(posedge clk_sys iff cycle_done === 1'b1);
        #1;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = $urandom(33);
        repeat (3) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        tcs_host_i.rd(8'h30, rd_v);
        chk(rd_v & 16'hfffd, 16'h0f9c);
        tcs_host_i.rd(8'h31, rd_v);
        chk(rd_v, 16'h0000);
        run_cfg(16'hff9c);
        @(posedge clk_sys iff conv_busy === 1'b1);
        repeat (3) @(posedge clk_sys);
        tcs_host_i.rd(8'h30, rd_v);
        chk(rd_v[1], 1'b1);
        wait_done(2);
        for (int k = 0; k < 3; k++) begin
            en_v = 9'($urandom_range(511, 1));
            run_cfg({en_v, 2'b10, 3'h7, 2'b00});
            wait_done(2);
        end
        for (int c = 0; c < 7; c++) begin
            run_cfg({9'h003, 2'b00, 3'(c), 2'b00});
            wait_done(2);
        end
        en_v = 9'($urandom_range(511, 1));
        run_cfg({en_v, 2'b11, 3'h7, 2'b00});
        wait_done(1);
        repeat (2 * REM) begin
            @(posedge clk_sys);
            #1;
            chk(conv_busy, 1'b0);
        end
        tcs_host_i.rd(8'h30, rd_v);
        chk(rd_v & 16'hfffd, {en_v, 2'b01, 3'h7, 2'b00});
        mon_on = 1'b0;
        tcs_host_i.wr(8'h30, 16'hff82);
        tcs_host_i.wr(8'h30, 16'h0042);
        tcs_host_i.rd(8'h30, rd_v);
        chk(rd_v & 16'hffe2, 16'h0020);
        repeat (LOC) @(posedge clk_sys);
        #1;
        chk(conv_busy, 1'b0);
        @(posedge clk_sys);
        #1;
        rstn = 1'b0;
        @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        tcs_host_i.rd(8'h30, rd_v);
        chk(rd_v & 16'hfffd, 16'h0f9c);
        end_sim();
    end
endmodule
